// >>> inc/switchgear_regs.svh
// Purpose: constants for the switchgear output control unit
// Assumes: 50 MHz system clock
// Notes: all offsets, codes and timing counts live here
`ifndef SWITCHGEAR_REGS_SVH
`define SWITCHGEAR_REGS_SVH
`define OBJ_COUNT 6
`define CODE_CFG_BASE 8'h14
`define CODE_CFG_LAST 8'h1F
`define CODE_DOC_BASE 8'hDC
`define CODE_DOC_LAST 8'hE7
`define CODE_IND_A 8'h28
`define CODE_IND_B 8'h29
`define CODE_NONE 8'h00
`define CH_FIRST 8
`define CH_COUNT 10
`define CH_AR_BLOCK 10
`define CH_ENERGY 11
`define TICK_NS 100000000
`define CLK_NS 20
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define PULSE_MIN 10'h001
`define PULSE_MAX 10'h3E8
`define PULSE_DEFAULT 10'h005
`define SCALE_MAX 20'hF4240
`define SCALE_DEFAULT 20'h04E20
`define SELFCHECK_CYCLES 8'h10
`endif

// >>> inc/switchgear_pkg.sv
// Purpose: types for the switchgear output control unit
// Assumes: nothing
// Notes: constants are in switchgear_regs.svh
package switchgear_pkg;
  typedef enum logic [3:0] {
    ST_SELFCHECK = 4'h1,
    ST_RUN = 4'h2,
    ST_SETTING = 4'h4,
    ST_FAULT = 4'h8
  } unit_state_t;
  typedef logic [9:0] pulse_len_t;
endpackage

// >>> inc/pulse_timer_if.sv
// Purpose: start and status of one pulse timer
// Assumes: one clock
// Notes: start is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface pulse_timer_if;
  logic start;
  logic [9:0] length;
  logic tick;
  logic abort;
  logic busy;
  modport owner (output start, output length, output tick, output abort, input busy);
  modport timer (input start, input length, input tick, input abort, output busy);
endinterface
`default_nettype wire

// >>> src/pulse_timer.sv
// Purpose: one command pulse timer counting 0.1 s ticks
// Assumes: tick is a one-cycle strobe
// Notes: a new start reloads the count
`timescale 1ns/10ps
`default_nettype none
module pulse_timer
  import switchgear_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control
  pulse_timer_if.timer tmr
);
  typedef struct packed {
    logic [9:0] count;
  } timer_state_t;
  timer_state_t st_r;
  timer_state_t st_nxt;

  // ==========================================================
  // Counter
  // Load on start, step down on tick, abort wins
  always_comb begin
    st_nxt = st_r;
    if (tmr.abort) begin
      st_nxt.count = 10'h000;
    end else if (tmr.start) begin
      st_nxt.count = tmr.length;
    end else if (tmr.tick && st_r.count != 10'h000) begin
      st_nxt.count = st_r.count - 10'h001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tmr.busy = (st_r.count != 10'h000);
endmodule
`default_nettype wire

// >>> src/switchgear_output_control.sv
// Purpose: command and indication outputs of a feeder control unit
// Assumes: all inputs synchronous to clock; interlock enables precomputed
// Notes: per-object pulse lengths in 0.1 s units, 1 to 1000
`timescale 1ns/10ps
`default_nettype none
`include "switchgear_regs.svh"

// Function
// - Outputs identified by codes 20..31, 220..231, 40/41; the code decodes only 20..31 and 40/41
// - Fourteen outputs: two indication, twelve commands
// - Pair: first opens, second closes object
// - Sources: panel, serial, channels, logic program
// - Auto-reclose may also drive command outputs
// - Panel, serial, channel requests give timed pulses
// - Output only active while interlock grants it
// - Separate off and on lengths per object
// - Pulse length 0.1 to 100 s, 0.1 s steps
// - Direct command: 0 opens, 1 closes
// - Secured: arm, then execute, if interlock allows
// - Execute or cancel clears armed state
// - Logic program output follows its control level
// - Blocking channel inhibits its target output while active
// - Interlock disabled: channels cannot block
// - Energy counter or reclose block input: single use
// - Default: channels neither activate nor block
// - Indications driven only by channels or program
// - Fault output high while healthy, low on fault
// - Current scale 0.00..10000.00, default 200.00
// - Store parameter 1 commits settings
// - Program mode 0 enters setting mode
// - Channel pulse length independent of input length
module switchgear_output_control
  import switchgear_pkg::*;
#(
  parameter int OBJS = `OBJ_COUNT,
  parameter int CHANS = `CH_COUNT,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Front panel buttons, one-cycle pulses, one bit per object
  input wire logic [5:0] panel_off_req,
  input wire logic [5:0] panel_on_req,
  // Serial commands, one-cycle strobes with object index
  input wire logic [2:0] serial_obj,
  input wire logic direct_command_param_wr,
  input wire logic direct_command_param,
  input wire logic arm_off_param,
  input wire logic arm_on_param,
  input wire logic execute_armed_param,
  input wire logic cancel_armed_param,
  // Pulse length writes, in 0.1 s units
  input wire logic off_pulse_length_wr,
  input wire logic on_pulse_length_wr,
  input wire logic [9:0] pulse_length_data,
  // Settings
  input wire logic interlock_use_setting,
  input wire logic program_mode_setting_wr,
  input wire logic program_mode_setting,
  input wire logic store_settings_param,
  input wire logic scale_wr,
  input wire logic [19:0] scale_data,
  // Input channels 8..17, levels, and their targets as output codes
  input wire logic [9:0] channel_active,
  input wire logic [79:0] input_activate_target,
  input wire logic [79:0] input_block_target,
  input wire logic energy_counter_mode,
  input wire logic ar_block_mode,
  // Interlock grants per output, bit 2k off, 2k+1 on
  input wire logic [11:0] interlock_grant,
  // Logic program and auto-reclose levels
  input wire logic [11:0] logic_cmd,
  input wire logic [1:0] logic_ind,
  input wire logic [11:0] auto_reclose_unit_cmd,
  input wire logic auto_reclose_enable,
  // Self check
  input wire logic self_check_pass,
  input wire logic permanent_fault,
  // Outputs
  output logic [5:0] object_off_output,
  output logic [5:0] object_on_output,
  output logic indication_out_a,
  output logic indication_out_b,
  output logic self_check_fault_out,
  output logic setting_mode,
  output logic store_strobe,
  output logic armed_any,
  output logic [19:0] current_scale_factor
);
  typedef struct packed {
    unit_state_t state;
    logic [31:0] tick_cnt;
    logic tick;
    logic [5:0] armed_off;
    logic [5:0] armed_on;
    logic [59:0] off_len;
    logic [59:0] on_len;
    logic [19:0] scale;
    logic [7:0] check_cnt;
    logic [5:0] off_out;
    logic [5:0] on_out;
    logic ind_a;
    logic ind_b;
    logic fault_ok;
    logic store;
  } ctl_state_t;
  ctl_state_t st_r;
  ctl_state_t st_nxt;

  // Timer starts and lengths toward the twelve timers
  logic [11:0] t_start;
  logic [11:0] t_abort;
  logic [11:0] t_busy;
  logic [119:0] t_len;

  // ==========================================================
  // Code decoding
  // Map a configuration code to command output index, or 12 if none
  function automatic logic [3:0] cfg_index(input logic [7:0] code);
    if (code >= `CODE_CFG_BASE && code <= `CODE_CFG_LAST) begin
      cfg_index = 4'(code - `CODE_CFG_BASE);
    end else begin
      cfg_index = 4'hC;
    end
  endfunction

  // Channel usable for routing unless reserved by a single-use mode
  function automatic logic chan_free(input int ch, input logic en_mode, input logic ar_mode);
    chan_free = !((ch + `CH_FIRST == `CH_ENERGY && en_mode) ||
                  (ch + `CH_FIRST == `CH_AR_BLOCK && ar_mode));
  endfunction

  // ==========================================================
  // Channel routing
  // Default targets are code 0, so channels do nothing until set
  logic [11:0] chan_trig;
  logic [11:0] chan_block;
  logic [1:0] chan_ind;
  logic [9:0] chan_prev_r;
  always_comb begin
    logic [3:0] ai;
    logic [3:0] bi;
    logic [7:0] ac;
    logic rise;
    chan_trig = 12'h000;
    chan_block = 12'h000;
    chan_ind = 2'b00;
    ai = 4'hC;
    bi = 4'hC;
    ac = `CODE_NONE;
    rise = 1'b0;
    for (int c = 0; c < CHANS; c++) begin
      ac = input_activate_target[c*8 +: 8];
      ai = cfg_index(ac);
      bi = cfg_index(input_block_target[c*8 +: 8]);
      rise = channel_active[c] && !chan_prev_r[c];
      if (chan_free(c, energy_counter_mode, ar_block_mode)) begin
        if (rise && ai != 4'hC) begin
          chan_trig[ai] = 1'b1;
        end
        if (channel_active[c] && bi != 4'hC && interlock_use_setting) begin
          chan_block[bi] = 1'b1;
        end
        if (channel_active[c] && ac == `CODE_IND_A) begin
          chan_ind[0] = 1'b1;
        end
        if (channel_active[c] && ac == `CODE_IND_B) begin
          chan_ind[1] = 1'b1;
        end
      end
    end
  end

  // Previous channel levels for edge detection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chan_prev_r <= '0;
    end else begin
      chan_prev_r <= channel_active;
    end
  end

  // ==========================================================
  // Pulse requests per output
  // Serial and panel requests are one-cycle strobes
  logic [11:0] req;
  logic [11:0] permit;
  always_comb begin
    req = 12'h000;
    for (int o = 0; o < OBJS; o++) begin
      req[2*o] = panel_off_req[o] || chan_trig[2*o];
      req[2*o+1] = panel_on_req[o] || chan_trig[2*o+1];
    end
    if (serial_obj < 3'(OBJS)) begin
      if (direct_command_param_wr) begin
        req[{serial_obj, direct_command_param}] = 1'b1;
      end
      if (execute_armed_param) begin
        req[{serial_obj, 1'b0}] |= st_r.armed_off[serial_obj];
        req[{serial_obj, 1'b1}] |= st_r.armed_on[serial_obj];
      end
    end
    // Without interlock use every operation is enabled
    permit = (interlock_use_setting ? interlock_grant : 12'hFFF) & ~chan_block;
  end

  // Timer hookups, starts gated by permit, aborts when permit drops
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_timer
      pulse_timer_if tif ();
      assign t_start[g] = req[g] && permit[g] && st_r.state == ST_RUN;
      assign t_abort[g] = !permit[g] || st_r.state != ST_RUN;
      assign t_len[g*10 +: 10] = (g % 2 == 1) ? st_r.on_len[(g/2)*10 +: 10]
                                      : st_r.off_len[(g/2)*10 +: 10];
      assign tif.start = t_start[g];
      assign tif.length = t_len[g*10 +: 10];
      assign tif.tick = st_r.tick;
      assign tif.abort = t_abort[g];
      assign t_busy[g] = tif.busy;
      pulse_timer u_timer (
        .clock(clock),
        .arst_n(arst_n),
        .tmr(tif)
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    logic [11:0] drive;
    drive = 12'h000;
    st_nxt = st_r;
    st_nxt.store = 1'b0;
    // 0.1 s tick from the system clock
    if (st_r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
      st_nxt.tick = 1'b0;
    end
    // Unit state
    case (st_r.state)
      ST_SELFCHECK: begin
        if (permanent_fault) begin
          st_nxt.state = ST_FAULT;
        end else if (self_check_pass && st_r.check_cnt >= `SELFCHECK_CYCLES) begin
          st_nxt.state = ST_RUN;
        end else if (st_r.check_cnt < `SELFCHECK_CYCLES) begin
          st_nxt.check_cnt = st_r.check_cnt + 8'h01;
        end
      end
      ST_RUN: begin
        if (permanent_fault) begin
          st_nxt.state = ST_FAULT;
        end else if (program_mode_setting_wr && !program_mode_setting) begin
          st_nxt.state = ST_SETTING;
        end
      end
      ST_SETTING: begin
        if (permanent_fault) begin
          st_nxt.state = ST_FAULT;
        end else if (program_mode_setting_wr && program_mode_setting) begin
          st_nxt.state = ST_RUN;
        end
      end
      ST_FAULT: begin
        st_nxt.state = ST_FAULT; // Permanent until reset
      end
      default: begin
        st_nxt.state = ST_SELFCHECK;
      end
    endcase
    st_nxt.fault_ok = (st_nxt.state == ST_RUN) || (st_nxt.state == ST_SETTING);
    // Arming; a new arm wins over an execute or cancel in the same cycle
    if (serial_obj < 3'(OBJS)) begin
      if (arm_off_param) begin
        st_nxt.armed_off[serial_obj] = 1'b1;
        st_nxt.armed_on[serial_obj] = 1'b0;
      end else if (arm_on_param) begin
        st_nxt.armed_on[serial_obj] = 1'b1;
        st_nxt.armed_off[serial_obj] = 1'b0;
      end else if (execute_armed_param || cancel_armed_param) begin
        st_nxt.armed_off[serial_obj] = 1'b0;
        st_nxt.armed_on[serial_obj] = 1'b0;
      end
      // Lengths out of range are refused
      if (pulse_length_data >= `PULSE_MIN && pulse_length_data <= `PULSE_MAX) begin
        if (off_pulse_length_wr) begin
          st_nxt.off_len[serial_obj*10 +: 10] = pulse_length_data;
        end
        if (on_pulse_length_wr) begin
          st_nxt.on_len[serial_obj*10 +: 10] = pulse_length_data;
        end
      end
    end
    if (scale_wr && scale_data <= `SCALE_MAX) begin
      st_nxt.scale = scale_data;
    end
    st_nxt.store = store_settings_param;
    // Outputs: timed pulses, program levels, reclose levels
    for (int k = 0; k < 12; k++) begin
      drive[k] = t_busy[k] || logic_cmd[k] || (auto_reclose_enable && auto_reclose_unit_cmd[k]);
    end
    drive = (st_nxt.state == ST_RUN) ? (drive & permit) : 12'h000;
    for (int o = 0; o < OBJS; o++) begin
      st_nxt.off_out[o] = drive[2*o];
      st_nxt.on_out[o] = drive[2*o+1];
    end
    st_nxt.ind_a = (st_nxt.state == ST_RUN) && (chan_ind[0] || logic_ind[0]);
    st_nxt.ind_b = (st_nxt.state == ST_RUN) && (chan_ind[1] || logic_ind[1]);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.state <= ST_SELFCHECK;
      st_r.off_len <= {6{`PULSE_DEFAULT}};
      st_r.on_len <= {6{`PULSE_DEFAULT}};
      st_r.scale <= `SCALE_DEFAULT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs from flip-flops; setting_mode and armed_any decoded from them
  assign object_off_output = st_r.off_out;
  assign object_on_output = st_r.on_out;
  assign indication_out_a = st_r.ind_a;
  assign indication_out_b = st_r.ind_b;
  assign self_check_fault_out = st_r.fault_ok;
  assign setting_mode = (st_r.state == ST_SETTING);
  assign store_strobe = st_r.store;
  assign armed_any = |{st_r.armed_off, st_r.armed_on};
  assign current_scale_factor = st_r.scale;
endmodule
`default_nettype wire

// >>> bench/switchgear_output_control_properties.sv
// Purpose: concurrent checks on the output control unit ports
// Assumes: one clock domain, reset low active and asynchronous
// Notes: run is read from the fault and setting outputs
`timescale 1ns/10ps
`default_nettype none
module switchgear_output_control_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Serial requests and settings
  input wire logic [2:0] serial_obj,
  input wire logic direct_command_param_wr,
  input wire logic direct_command_param,
  input wire logic arm_off_param,
  input wire logic execute_armed_param,
  input wire logic program_mode_setting_wr,
  input wire logic program_mode_setting,
  input wire logic store_settings_param,
  input wire logic interlock_use_setting,
  input wire logic [11:0] interlock_grant,
  input wire logic [9:0] channel_active,
  input wire logic [79:0] input_block_target,
  input wire logic [11:0] logic_cmd,
  input wire logic permanent_fault,
  input wire logic scale_wr,
  input wire logic [19:0] scale_data,
  // Outputs
  input wire logic [5:0] object_off_output,
  input wire logic [5:0] object_on_output,
  input wire logic self_check_fault_out,
  input wire logic setting_mode,
  input wire logic store_strobe,
  input wire logic armed_any,
  input wire logic [19:0] current_scale_factor
);
  // ==========
  // Requests only count while healthy and out of setting mode
  wire run = self_check_fault_out && !setting_mode;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Steps of direct and secured control
  sequence s_direct_on0;
    run && direct_command_param_wr && direct_command_param && serial_obj == 3'h0
      && !interlock_use_setting && channel_active == 10'h000;
  endsequence
  sequence s_arm_exec2;
    (run && arm_off_param && serial_obj == 3'h2 && !interlock_use_setting)
      ##2 (execute_armed_param && serial_obj == 3'h2);
  endsequence
  // ==========
  a_reset_fault_low: assert property ($rose(arst_n) |-> !self_check_fault_out [*8])
    else $error("fault output high too soon after reset");
  a_direct_close: assert property (s_direct_on0 |-> ##2 object_on_output[0])
    else $error("direct close gave no pulse");
  a_arm_exec: assert property (s_arm_exec2 |-> ##2 (!armed_any && object_off_output[2]))
    else $error("execute did not fire armed output or clear arming");
  a_store_strobe: assert property (store_settings_param |=> store_strobe)
    else $error("store request gave no strobe");
  a_setting_enter: assert property (run && program_mode_setting_wr
    && !program_mode_setting |=> setting_mode)
    else $error("setting mode not entered");
  a_fault_drops: assert property (permanent_fault |-> ##[1:2] !self_check_fault_out)
    else $error("fault output stayed high on fault");
  a_no_grant: assert property (interlock_use_setting && interlock_grant == 12'h000
    |=> (object_off_output | object_on_output) == 6'h00)
    else $error("command output without grant");
  a_block_holds: assert property (interlock_use_setting && channel_active[2]
    && input_block_target[23:16] == 8'h15 |=> !object_on_output[0])
    else $error("blocked output active");
  a_logic_follow: assert property (run && !interlock_use_setting && logic_cmd[10]
    |=> object_off_output[5])
    else $error("program output not following");
  a_scale_range: assert property (scale_wr && scale_data > 20'hF4240
    |=> $stable(current_scale_factor))
    else $error("out of range scale accepted");
endmodule
bind switchgear_output_control switchgear_output_control_properties u_props (.*);
`default_nettype wire

// >>> bench/breaker_bank.sv
// Purpose: six switching objects worked by the command relays
// Assumes: one coil per command output
// Notes: reports a finished coil pulse with its length in cycles, only the highest-numbered coil when several drop in one cycle
`timescale 1ns/10ps
`default_nettype none
module breaker_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Relay coils
  input wire logic [5:0] off_cmd,
  input wire logic [5:0] on_cmd,
  // Finished pulse report and object positions
  output logic done,
  output logic [2:0] done_obj,
  output logic done_dir,
  output int done_len,
  output logic [5:0] closed
);
  int cnt [12];
  wire [11:0] coil = {on_cmd, off_cmd};
  // Time each coil; the object moves when the coil drops
  always @(posedge clock or negedge arst_n) begin
    done <= 1'h0;
    if (!arst_n) begin
      closed <= 6'h00;
      for (int k = 0; k < 12; k++) cnt[k] <= 0;
    end else begin
      for (int k = 0; k < 12; k++) begin
        if (coil[k]) begin
          cnt[k] <= cnt[k] + 1;
        end else if (cnt[k] != 0) begin
          done <= 1'h1;
          done_obj <= 3'(k % 6);
          done_dir <= (k >= 6);
          done_len <= cnt[k];
          cnt[k] <= 0;
          closed[k % 6] <= (k >= 6);
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_switchgear_output_control.sv
// Purpose: self-checking bench for the output control unit
// Assumes: tick shortened to 10 cycles
// Notes: pulses are noted in a queue and matched as the breakers report them
`timescale 1ns/10ps
`default_nettype none
module test_switchgear_output_control
  import switchgear_pkg::*;
;
  localparam int T = 10;
  typedef struct {logic [2:0] o; logic d; int lo; int hi;} note_t;
  note_t q[$];
  logic clock, arst_n;
  logic [5:0] panel_off_req, panel_on_req, object_off_output, object_on_output;
  logic [2:0] serial_obj, done_obj;
  logic direct_command_param_wr, direct_command_param, arm_off_param, arm_on_param;
  logic execute_armed_param, cancel_armed_param, off_pulse_length_wr, on_pulse_length_wr;
  logic interlock_use_setting, program_mode_setting_wr, program_mode_setting;
  logic store_settings_param, scale_wr, energy_counter_mode, ar_block_mode;
  logic auto_reclose_enable, self_check_pass, permanent_fault, done, done_dir;
  logic indication_out_a, indication_out_b, self_check_fault_out, setting_mode;
  logic store_strobe, armed_any;
  pulse_len_t pulse_length_data;
  logic [9:0] channel_active;
  logic [79:0] input_activate_target, input_block_target;
  logic [11:0] interlock_grant, logic_cmd, auto_reclose_unit_cmd;
  logic [1:0] logic_ind;
  logic [19:0] scale_data, current_scale_factor, v;
  int done_len, mismatches = 0, n_checks = 0, seed = 32'hAF3C;
  // ==========
  switchgear_output_control #(.TICK_CYCLES(T)) u_dut (.*);
  breaker_bank u_bank (.clock(clock), .arst_n(arst_n), .off_cmd(object_off_output),
    .on_cmd(object_on_output), .done(done), .done_obj(done_obj), .done_dir(done_dir),
    .done_len(done_len), .closed());
  // Free-running 50 MHz clock
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // ==========
  task automatic check_val(input string name, input logic [19:0] exp, input logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_pulse;
    note_t n;
    n_checks++;
    n = note_t'{3'h7, 1'h0, 0, 0};
    if (q.size() != 0) n = q.pop_front();
    if (done_obj !== n.o || done_dir !== n.d || done_len < n.lo || done_len > n.hi) begin
      mismatches++;
      $display("mismatch pulse expected %0d %0d %0d..%0d seen %0d %0d %0d",
        n.o, n.d, n.lo, n.hi, done_obj, done_dir, done_len);
    end
  endtask
  task automatic exp_timed(input logic [2:0] o, input logic d, input int l);
    q.push_back(note_t'{o, d, (l - 1) * T, l * T + 3});
  endtask
  // One strobe for one edge; k picks the parameter, d the level, x the data
  task automatic ser(input logic [2:0] o, input int k, input logic d, input logic [19:0] x);
    @(posedge clock);
    serial_obj <= o;
    direct_command_param <= d;
    program_mode_setting <= d;
    pulse_length_data <= x[9:0];
    scale_data <= x;
    direct_command_param_wr <= (k == 0);
    arm_off_param <= (k == 1);
    arm_on_param <= (k == 2);
    execute_armed_param <= (k == 3);
    cancel_armed_param <= (k == 4);
    off_pulse_length_wr <= (k == 5);
    on_pulse_length_wr <= (k == 6);
    program_mode_setting_wr <= (k == 7);
    store_settings_param <= (k == 8);
    scale_wr <= (k == 9);
    @(posedge clock);
    {direct_command_param_wr, arm_off_param, arm_on_param, execute_armed_param} <= 4'h0;
    {cancel_armed_param, off_pulse_length_wr, on_pulse_length_wr} <= 3'h0;
    {program_mode_setting_wr, store_settings_param, scale_wr} <= 3'h0;
  endtask
  // Wait out noted pulses, then long enough to catch a stray one
  task automatic drain;
    for (int i = 0; i < 12000 && q.size() != 0; i++) @(posedge clock);
    repeat (T * 6 + 4) @(posedge clock);
    check_val("pending pulses", 20'h00000, 20'(q.size()));
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========
  // Match every finished pulse against the oldest note
  always @(negedge clock) if (done === 1'h1) check_pulse();
  // Cut a hang short
  initial begin
    #(20 * 60000);
    mismatches++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {panel_off_req, panel_on_req, serial_obj, pulse_length_data, scale_data} = '0;
    {channel_active, input_activate_target, input_block_target, logic_ind} = '0;
    {interlock_grant, logic_cmd, auto_reclose_unit_cmd, scale_wr} = '0;
    {direct_command_param_wr, direct_command_param, arm_off_param, arm_on_param} = '0;
    {execute_armed_param, cancel_armed_param, off_pulse_length_wr, on_pulse_length_wr} = '0;
    {program_mode_setting_wr, store_settings_param, interlock_use_setting} = '0;
    {energy_counter_mode, ar_block_mode, auto_reclose_enable, permanent_fault} = '0;
    program_mode_setting = 1'h1;
    self_check_pass = 1'h1;
    arst_n = 1'h0;
    repeat (12) @(posedge clock);
    arst_n <= 1'h1;
    @(negedge clock);
    check_val("fault out", 20'h00000, 20'(self_check_fault_out));
    check_val("scale", 20'h04E20, current_scale_factor);
    ser(3'h0, 0, 1'h1, 20'h0);
    for (int i = 0; i < 100 && self_check_fault_out !== 1'h1; i++) @(negedge clock);
    check_val("fault out", 20'h00001, 20'(self_check_fault_out));
    ser(3'h0, 0, 1'h1, 20'h0);
    exp_timed(3'h0, 1'h1, 5);
    drain();
    // Lengths: random, refused out of range, then the maximum
    v = 20'(1 + ($unsigned($random(seed)) % 8));
    ser(3'h1, 5, 1'h0, v);
    ser(3'h1, 5, 1'h0, 20'h003E9);
    ser(3'h1, 5, 1'h0, 20'h00000);
    ser(3'h1, 0, 1'h0, 20'h0);
    exp_timed(3'h1, 1'h0, int'(v));
    drain();
    ser(3'h1, 6, 1'h0, 20'h003E8);
    ser(3'h1, 0, 1'h1, 20'h0);
    exp_timed(3'h1, 1'h1, 1000);
    drain();
    // Secured control, executed and cancelled, then a panel button
    ser(3'h2, 1, 1'h0, 20'h0);
    ser(3'h2, 3, 1'h0, 20'h0);
    exp_timed(3'h2, 1'h0, 5);
    ser(3'h3, 2, 1'h0, 20'h0);
    repeat (2) @(negedge clock);
    check_val("armed", 20'h00001, 20'(armed_any));
    ser(3'h3, 4, 1'h0, 20'h0);
    repeat (2) @(negedge clock);
    check_val("armed", 20'h00000, 20'(armed_any));
    ser(3'h3, 3, 1'h0, 20'h0);
    drain();
    @(posedge clock);
    panel_on_req <= 6'h08;
    @(posedge clock);
    panel_on_req <= 6'h00;
    exp_timed(3'h3, 1'h1, 5);
    drain();
    // Interlock refuses, then grants
    @(posedge clock);
    interlock_use_setting <= 1'h1;
    ser(3'h4, 0, 1'h1, 20'h0);
    drain();
    interlock_grant <= 12'hFFF;
    ser(3'h4, 0, 1'h1, 20'h0);
    exp_timed(3'h4, 1'h1, 5);
    drain();
    // Channel block holds, then lapses with interlocking out of use
    input_block_target[23:16] <= 8'h15;
    channel_active[2] <= 1'h1;
    ser(3'h0, 0, 1'h1, 20'h0);
    drain();
    interlock_use_setting <= 1'h0;
    ser(3'h0, 0, 1'h1, 20'h0);
    exp_timed(3'h0, 1'h1, 5);
    drain();
    // Channel activation: long input, timed pulse, level indication
    channel_active <= 10'h000;
    energy_counter_mode <= 1'h1;
    input_activate_target[31:0] <= 32'h1A002818;
    @(posedge clock);
    channel_active <= 10'h00B;
    exp_timed(3'h2, 1'h0, 5);
    repeat (120) @(negedge clock);
    check_val("indication a", 20'h00001, 20'(indication_out_a));
    @(posedge clock);
    channel_active <= 10'h000;
    repeat (3) @(negedge clock);
    check_val("indication a", 20'h00000, 20'(indication_out_a));
    drain();
    // Logic program and auto-reclose follow their levels
    logic_cmd <= 12'h400;
    logic_ind <= 2'h2;
    q.push_back(note_t'{3'h5, 1'h0, 29, 31});
    repeat (30) @(posedge clock);
    logic_cmd <= 12'h000;
    @(negedge clock);
    check_val("indication b", 20'h00001, 20'(indication_out_b));
    drain();
    auto_reclose_enable <= 1'h1;
    auto_reclose_unit_cmd <= 12'h200;
    q.push_back(note_t'{3'h4, 1'h1, 19, 21});
    repeat (20) @(posedge clock);
    auto_reclose_unit_cmd <= 12'h000;
    drain();
    // Scale, store and setting mode
    v = 20'($unsigned($random(seed)) % 1000001);
    ser(3'h0, 9, 1'h0, v);
    ser(3'h0, 9, 1'h0, 20'hF4241);
    repeat (2) @(negedge clock);
    check_val("scale", v, current_scale_factor);
    ser(3'h0, 8, 1'h0, 20'h0);
    @(negedge clock);
    check_val("store strobe", 20'h00001, 20'(store_strobe));
    ser(3'h0, 7, 1'h0, 20'h0);
    repeat (2) @(negedge clock);
    check_val("setting mode", 20'h00001, 20'(setting_mode));
    ser(3'h0, 0, 1'h1, 20'h0);
    ser(3'h0, 7, 1'h1, 20'h0);
    drain();
    permanent_fault <= 1'h1;
    repeat (3) @(negedge clock);
    check_val("fault out", 20'h00000, 20'(self_check_fault_out));
    report_and_stop();
  end
endmodule
`default_nettype wire
